// ==== rtl/pgc_regs.vh ====
/*
 * Constants for the power gating control block: register offsets,
 * field positions, writable masks, reset values and the idle count.
 * Assumes it is included by bare name into the pgc design files.
 */
`ifndef PGC_REGS_VH
`define PGC_REGS_VH

// Register offsets on the multiplexed address/data bus
`define PGC_OFF_CTRL_ZERO 8'hb0
`define PGC_OFF_CTRL_TWO 8'hb4

// Control register zero fields
`define PGC_Z_AUTO_PD_EN 1
`define PGC_Z_TURBO_OFF 3
`define PGC_Z_ARRAY_CLK_OFF 4
`define PGC_Z_MCELL_CLK_OFF 5
`define PGC_Z_WMASK 8'h3a

// Control register two fields
`define PGC_T_WR_OFF 2
`define PGC_T_RD_OFF 3
`define PGC_T_PSEN_OFF 4
`define PGC_T_ALE_OFF 5
`define PGC_T_WMASK 8'h3c

// Reset values: turbo on, every input connected, auto power-down off
`define PGC_RST_CTRL_ZERO 8'h00
`define PGC_RST_CTRL_TWO 8'h00

// Idle periods of the external clock before power-down
`define PGC_AUTO_PD_IDLE 4'hf

`endif

// ==== rtl/pgc_apd.v ====
/*
 * Automatic power-down unit: four-bit idle counter on the external clock.
 * Assumes all inputs are synchronous to sys_clk and the external clock
 * edge arrives as a one-cycle pulse.
 */
`timescale 1ns/10ps
`include "pgc_regs.vh"

module pgc_idle_down #(
    parameter CNT_W = 4
) (
    input wire sys_clk,
    input wire rst_b,
    input wire auto_pd_en,
    input wire clk_rise,
    input wire ale,
    input wire ale_rise,
    input wire csi_b,
    input wire dev_reset,
    output wire power_down
);

reg [CNT_W-1:0] idle_q;
reg down_q;

// Idle counter and power-down flag
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        idle_q <= {CNT_W{1'b0}};
        down_q <= 1'b0;
    end
    else if (!auto_pd_en || ale_rise || !csi_b || dev_reset)
    begin
        idle_q <= {CNT_W{1'b0}};
        down_q <= 1'b0;
    end
    else if (ale)
    begin
        idle_q <= {CNT_W{1'b0}};
    end
    else if (clk_rise && !down_q)
    begin
        // Clock reaches the counter whatever the gating bits say
        if (idle_q == `PGC_AUTO_PD_IDLE - 4'h1)
            down_q <= 1'b1;
        idle_q <= idle_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

assign power_down = down_q;

endmodule // pgc_idle_down

// ==== rtl/pgc_gate.v ====
/*
 * Input gating toward the logic array and macrocells.
 * Assumes registered control bits and synchronous strobe inputs.
 */
`timescale 1ns/10ps
`include "pgc_regs.vh"

module pgc_gate (
    input wire [7:0] ctrl_zero,
    input wire [7:0] ctrl_two,
    input wire ext_clk,
    input wire clk_edge,
    input wire wr_b,
    input wire rd_b,
    input wire psen_b,
    input wire ale,
    output wire array_clk,
    output wire mcell_clk,
    output wire array_wake,
    output wire array_wr_b,
    output wire array_rd_b,
    output wire array_psen_b,
    output wire array_ale
);

// Clock to array and macrocells unless cut off
assign array_clk = ext_clk & ~ctrl_zero[`PGC_Z_ARRAY_CLK_OFF];
assign mcell_clk = ext_clk & ~ctrl_zero[`PGC_Z_MCELL_CLK_OFF];
// Clock transitions wake the array only with turbo on
assign array_wake = clk_edge & ~ctrl_zero[`PGC_Z_ARRAY_CLK_OFF]
    & ~ctrl_zero[`PGC_Z_TURBO_OFF];
// Disconnected strobes rest at their inactive level
assign array_wr_b = wr_b | ctrl_two[`PGC_T_WR_OFF];
assign array_rd_b = rd_b | ctrl_two[`PGC_T_RD_OFF];
assign array_psen_b = psen_b | ctrl_two[`PGC_T_PSEN_OFF];
assign array_ale = ale & ~ctrl_two[`PGC_T_ALE_OFF];

endmodule // pgc_gate

// ==== rtl/pgc_top.v ====
/*
 * Power gating control for the programmable logic section: chip-select
 * gating of the memories, two power control registers on the 8032
 * multiplexed bus, clock and strobe disconnects, turbo and auto power-down.
 * Assumes bus pins and the external clock are synchronous to sys_clk
 * (10 MHz) and slow enough to be sampled; ALE is active high, strobes low.
 * The external clock must hold each level for at least two sys_clk cycles.
 * Only the two mapped low-byte offsets are written or driven on reads.
 */
`timescale 1ns/10ps
`include "pgc_regs.vh"

// Notes on behaviour
// - Chip-select low enables flash, SRAM and I/O for reads and writes.
// - Chip-select high disables flash and SRAM.
// - Chip-select high also disables I/O; logic keeps running.
// - External clock feeds logic array and output macrocells.
// - Register zero bits 4 and 5 cut clock from array and macrocells.
// - With turbo on, each array clock transition powers up the array.
// - Register zero bit 1 enables auto power-down.
// - Register zero bit 3: zero turbo on, one turbo off.
// - Register two bits 2 to 5 cut write, read, PSEN, ALE from array.
// - Fifteen idle clock periods of ALE enter power-down.
// - ALE pulse, chip-select low or reset high leave power-down.
// - Clock cut-off never stops the power-down counter.
module pgc_top (
    input wire sys_clk,
    input wire rst_b,
    input wire dev_reset,
    input wire port_d_pin_two,
    input wire ext_logic_clock_in,
    input wire mcu_ale,
    input wire mcu_wr_b,
    input wire mcu_rd_b,
    input wire mcu_psen_b,
    input wire [7:0] mcu_ad_in,
    output reg [7:0] mcu_ad_out,
    output reg mcu_ad_oe,
    output reg mem_enable,
    output reg io_enable,
    output reg turbo_on,
    output reg power_down_flag,
    output reg array_clk_q,
    output reg mcell_clk_q,
    output reg array_wake_q,
    output reg array_wr_b_q,
    output reg array_rd_b_q,
    output reg array_psen_b_q,
    output reg array_ale_q
);

reg [7:0] ctrl_zero_q;
reg [7:0] ctrl_two_q;
reg [7:0] addr_q;
reg clk_prev_q;
reg ale_prev_q;
reg wr_prev_q;
reg edge_arm_q;
wire clk_edge;
wire clk_rise;
wire ale_rise;
wire wr_fall;
wire idle_down;
wire g_array_clk;
wire g_mcell_clk;
wire g_wake;
wire g_wr_b;
wire g_rd_b;
wire g_psen_b;
wire g_ale;
reg [7:0] rd_data;
reg rd_hit;

// Address match on the latched low byte
function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
        hit = (addr == off);
    end
endfunction

// Edge detectors stay quiet for the first cycle after reset
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        edge_arm_q <= 1'b0;
    else
        edge_arm_q <= 1'b1;
end

// Previous level of the external clock
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        clk_prev_q <= 1'b0;
    else
        clk_prev_q <= ext_logic_clock_in;
end

// Previous level of the address latch strobe
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        ale_prev_q <= 1'b0;
    else
        ale_prev_q <= mcu_ale;
end

// Previous level of the write strobe, idle high
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        wr_prev_q <= 1'b1;
    else
        wr_prev_q <= mcu_wr_b;
end

// Edges between two samples; a pin already high at release is no edge
assign clk_edge = edge_arm_q & (ext_logic_clock_in ^ clk_prev_q);
assign clk_rise = edge_arm_q & ext_logic_clock_in & ~clk_prev_q;
assign ale_rise = edge_arm_q & mcu_ale & ~ale_prev_q;
assign wr_fall = edge_arm_q & ~mcu_wr_b & wr_prev_q;

// Address latch while ALE is high
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        addr_q <= 8'h00;
    else if (mcu_ale)
        addr_q <= mcu_ad_in;
end

// Write taken on the first low sample of the strobe, address phase over
function wr_take;
    input fall;
    input ale_lvl;
    input [7:0] addr;
    input [7:0] off;
    begin
        wr_take = fall & ~ale_lvl & hit(addr, off);
    end
endfunction

// Power control register zero, unused bits stored as zero
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        ctrl_zero_q <= `PGC_RST_CTRL_ZERO;
    else if (wr_take(wr_fall, mcu_ale, addr_q, `PGC_OFF_CTRL_ZERO))
        ctrl_zero_q <= mcu_ad_in & `PGC_Z_WMASK;
end

// Power control register two, unused bits stored as zero
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        ctrl_two_q <= `PGC_RST_CTRL_TWO;
    else if (wr_take(wr_fall, mcu_ale, addr_q, `PGC_OFF_CTRL_TWO))
        ctrl_two_q <= mcu_ad_in & `PGC_T_WMASK;
end

// Read data select
always @*
begin
    rd_data = 8'h00;
    rd_hit = 1'b0;
    if (hit(addr_q, `PGC_OFF_CTRL_ZERO))
    begin
        rd_data = ctrl_zero_q;
        rd_hit = 1'b1;
    end
    else if (hit(addr_q, `PGC_OFF_CTRL_TWO))
    begin
        rd_data = ctrl_two_q;
        rd_hit = 1'b1;
    end
end

// Read data follows the selected register every cycle
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        mcu_ad_out <= 8'h00;
    else
        mcu_ad_out <= rd_data;
end

// Drive the bus only while a mapped register is read
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        mcu_ad_oe <= 1'b0;
    else
        mcu_ad_oe <= rd_hit & ~mcu_rd_b & ~mcu_ale;
end

// Auto power-down counter, fed by the ungated clock
pgc_idle_down #(
    .CNT_W(4)
) u_idle (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .auto_pd_en(ctrl_zero_q[`PGC_Z_AUTO_PD_EN]),
    .clk_rise(clk_rise),
    .ale(mcu_ale),
    .ale_rise(ale_rise),
    .csi_b(port_d_pin_two),
    .dev_reset(dev_reset),
    .power_down(idle_down)
);

// Clock and strobe gating toward the logic
pgc_gate u_gate (
    .ctrl_zero(ctrl_zero_q),
    .ctrl_two(ctrl_two_q),
    .ext_clk(ext_logic_clock_in),
    .clk_edge(clk_edge),
    .wr_b(mcu_wr_b),
    .rd_b(mcu_rd_b),
    .psen_b(mcu_psen_b),
    .ale(mcu_ale),
    .array_clk(g_array_clk),
    .mcell_clk(g_mcell_clk),
    .array_wake(g_wake),
    .array_wr_b(g_wr_b),
    .array_rd_b(g_rd_b),
    .array_psen_b(g_psen_b),
    .array_ale(g_ale)
);

// Memory and I/O selects from chip-select
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        mem_enable <= 1'b0;
        io_enable <= 1'b0;
    end
    else
    begin
        // Memories selected only with chip-select low and not powered down
        mem_enable <= ~port_d_pin_two & ~idle_down;
        io_enable <= ~port_d_pin_two;
    end
end

// Turbo and power-down status
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        turbo_on <= 1'b1;
        power_down_flag <= 1'b0;
    end
    else
    begin
        turbo_on <= ~ctrl_zero_q[`PGC_Z_TURBO_OFF];
        power_down_flag <= idle_down;
    end
end

// Clock copies toward array and macrocells; chip-select plays no part
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        array_clk_q <= 1'b0;
        mcell_clk_q <= 1'b0;
        array_wake_q <= 1'b0;
    end
    else
    begin
        array_clk_q <= g_array_clk;
        mcell_clk_q <= g_mcell_clk;
        array_wake_q <= g_wake;
    end
end

// Strobe copies toward the array, idle level when cut off
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        array_wr_b_q <= 1'b1;
        array_rd_b_q <= 1'b1;
        array_psen_b_q <= 1'b1;
        array_ale_q <= 1'b0;
    end
    else
    begin
        array_wr_b_q <= g_wr_b;
        array_rd_b_q <= g_rd_b;
        array_psen_b_q <= g_psen_b;
        array_ale_q <= g_ale;
    end
end

endmodule // pgc_top

// ==== verif/pgc_top_props.sv ====
/* Port checker for pgc_top.
   Bound to every pgc_top; sees only its ports, one sys_clk domain. */
`timescale 1ns/10ps
module pgc_top_props (
    input wire sys_clk,
    input wire rst_b,
    input wire dev_reset,
    input wire port_d_pin_two,
    input wire ext_logic_clock_in,
    input wire mcu_ale,
    input wire mcu_wr_b,
    input wire mcu_rd_b,
    input wire mcu_ad_oe,
    input wire mem_enable,
    input wire turbo_on,
    input wire power_down_flag,
    input wire array_clk_q,
    input wire array_wake_q,
    input wire array_wr_b_q,
    input wire array_ale_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Memory select, gating and read drive tied to their causes
    a_mem_desel: assert property (mem_enable |-> !$past(port_d_pin_two))
        else $error("memory enabled while deselected");
    a_arr_clk_gate: assert property (array_clk_q |-> $past(ext_logic_clock_in))
        else $error("array clock without input clock");
    a_wr_gate: assert property (!array_wr_b_q |-> !$past(mcu_wr_b))
        else $error("array write without bus write");
    a_ale_gate: assert property (array_ale_q |-> $past(mcu_ale))
        else $error("array ale without bus ale");
    a_read_drive: assert property (mcu_ad_oe |-> !$past(mcu_rd_b))
        else $error("bus driven without read");
    // Power-down entry and exit, turbo wake pulse
    a_csi_exit: assert property (!port_d_pin_two |-> ##2 !power_down_flag)
        else $error("power-down held while selected");
    a_reset_exit: assert property (dev_reset |-> ##2 !power_down_flag)
        else $error("power-down held in reset");
    a_pd_entry: assert property ($rose(power_down_flag) |->
        $past(port_d_pin_two, 2) && !$past(mcu_ale, 2))
        else $error("power-down entered while active");
    a_wake_turbo: assert property (array_wake_q |-> turbo_on ##1 !array_wake_q)
        else $error("wake pulse wrong");
    c_pd_entry: cover property ($rose(power_down_flag));
    c_read: cover property ($rose(mcu_ad_oe));
    c_wake: cover property (array_wake_q);
endmodule // pgc_top_props

bind pgc_top pgc_top_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
    .dev_reset(dev_reset), .port_d_pin_two(port_d_pin_two),
    .ext_logic_clock_in(ext_logic_clock_in), .mcu_ale(mcu_ale), .mcu_wr_b(mcu_wr_b),
    .mcu_rd_b(mcu_rd_b), .mcu_ad_oe(mcu_ad_oe), .mem_enable(mem_enable),
    .turbo_on(turbo_on), .power_down_flag(power_down_flag), .array_clk_q(array_clk_q),
    .array_wake_q(array_wake_q), .array_wr_b_q(array_wr_b_q), .array_ale_q(array_ale_q));

// ==== verif/pgc_mcu.sv ====
/* Bus master model of the 8032 multiplexed bus.
   Assumes sys_clk from the bench; changes lines 1 ns after rising edges. */
`timescale 1ns/10ps
module pgc_mcu (
    input wire sys_clk,
    output reg ale,
    output reg wr_b,
    output reg rd_b,
    output reg [7:0] ad
);
    initial {ale, wr_b, rd_b, ad} = 11'h300;
    // Address phase, strobe held two edges, bus left changing after
    task cyc(input [7:0] a, input [7:0] d, input w);
        begin
            @(posedge sys_clk) #1 ale = 1'b1;
            ad = a;
            @(posedge sys_clk) #1 ale = 1'b0;
            ad = ~a;
            @(posedge sys_clk) #1 ad = d;
            if (w) wr_b = 1'b0;
            else rd_b = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1 {wr_b, rd_b} = 2'b11;
            ad = ~d;
            @(posedge sys_clk);
        end
    endtask
endmodule // pgc_mcu

// ==== verif/pgc_top_test.sv ====
/* Self-checking bench for pgc_top.
   Uses pgc_mcu as bus master; reads are checked from a queue. */
`timescale 1ns/10ps
module pgc_top_test;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg dev_reset = 1'b0;
    reg csi = 1'b0;
    reg ext = 1'b0;
    reg [1:0] cut = 2'b00;
    reg psen = 1'b0;
    wire ale, wr_b, rd_b, oe, mem_en, turbo, pd_flag, aclk, mclk, ard, ioe, apsen;
    wire [7:0] ad, ad_out;
    integer err_total = 0;
    integer checked = 0;
    integer k, n;
    reg [7:0] r;
    reg [7:0] exp_q[$];
    always #50 sys_clk = ~sys_clk;
    // Input clock at 2.5 MHz, changing on sys_clk falling edges
    always #200 ext = ~ext;
    pgc_mcu u_mcu (.sys_clk(sys_clk), .ale(ale), .wr_b(wr_b), .rd_b(rd_b), .ad(ad));
    pgc_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .dev_reset(dev_reset),
        .port_d_pin_two(csi), .ext_logic_clock_in(ext), .mcu_ale(ale), .mcu_wr_b(wr_b),
        .mcu_rd_b(rd_b), .mcu_psen_b(psen), .mcu_ad_in(ad), .mcu_ad_out(ad_out),
        .mcu_ad_oe(oe), .mem_enable(mem_en), .io_enable(ioe), .turbo_on(turbo),
        .power_down_flag(pd_flag), .array_clk_q(aclk), .mcell_clk_q(mclk), .array_wake_q(),
        .array_wr_b_q(), .array_rd_b_q(ard), .array_psen_b_q(apsen), .array_ale_q());
    task chk(input [7:0] seen, input [7:0] want, input string what);
        begin
            checked = checked + 1;
            if (seen !== want)
            begin
                err_total = err_total + 1;
                $display("MISMATCH %s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e, input hit);
        begin
            if (hit) exp_q.push_back(e);
            u_mcu.cyc(a, ~a, 1'b0);
        end
    endtask
    // Power-down must come fifteen input clock rises after bus activity
    task wait_pd;
        begin
            n = 0;
            while (pd_flag !== 1'b1 && n < 90)
            begin
                @(posedge sys_clk) #1 n = n + 1;
            end
            chk(8'(n > 49 && n < 66), 8'h01, "entry time");
            chk(8'(mem_en), 8'h00, "mem in pd");
        end
    endtask
    // Compare each read answer with the oldest expected value
    always @(posedge oe)
    begin
        #1 chk(8'(exp_q.size() != 0), 8'h01, "read hit");
        if (exp_q.size() != 0) chk(ad_out, exp_q.pop_front(), "read data");
        chk(8'(ard), 8'(cut[0]), "array rd");
        chk(8'(apsen), 8'(cut[1]), "array psen");
    end
    initial
    begin
        void'($urandom(85));
        repeat (20) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        chk(8'(turbo), 8'h01, "turbo reset");
        rd(8'hb0, 8'h00, 1'b1);
        rd(8'hb4, 8'h00, 1'b1);
        rd(8'h55, 8'h00, 1'b0);
        chk(8'(mem_en), 8'h01, "selected");
        chk(8'(ioe), 8'h01, "io selected");
        r = 8'($urandom);
        u_mcu.cyc(8'hb4, r, 1'b1);
        cut = r[4:3];
        rd(8'hb4, r & 8'h3c, 1'b1);
        u_mcu.cyc(8'hb0, 8'h18, 1'b1);
        chk(8'(turbo), 8'h00, "turbo off");
        #1 csi = 1'b1;
        r = 8'h00;
        repeat (12) @(posedge sys_clk) #1 r = r | {6'h00, mclk, aclk};
        chk(r, 8'h02, "clock cut");
        chk(8'(mem_en), 8'h00, "deselected");
        chk(8'(ioe), 8'h00, "io deselected");
        u_mcu.cyc(8'hb4, 8'h3c, 1'b1);
        cut = 2'b11;
        u_mcu.cyc(8'hb0, 8'h32, 1'b1);
        wait_pd;
        // Leave power-down by chip-select, device reset, then bus activity
        for (k = 0; k < 3; k = k + 1)
        begin
            @(posedge sys_clk) #1 csi = (k != 0);
            dev_reset = (k == 1);
            repeat (3) @(posedge sys_clk);
            #1 {csi, dev_reset} = 2'b10;
            chk(8'(pd_flag), 8'(k == 2), "pd hold");
            rd(8'hb0, 8'h32, 1'b1);
            chk(8'(pd_flag), 8'h00, "pd exit");
            wait_pd;
        end
        chk(8'(exp_q.size()), 8'h00, "reads left");
        test_done;
    end
    initial
    begin
        #2000000;
        err_total = err_total + 1;
        test_done;
    end
endmodule // pgc_top_test
